// ===== dv/acmr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host side: register writes and reads, sequencer pulses
// ----------------------------------------
module acmr_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic channel_switch,
    output logic conversion_done
);
    localparam logic [15:0] RSV_BITS = 16'h5883;

    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        channel_switch = 1'b0;
        conversion_done = 1'b0;
    end

    // reserved positions go out as zero while the write strobe is high
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d & ~RSV_BITS;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata; // released data is not the last value
    endtask

    task automatic read(input logic [7:0] a);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
    endtask

    // one-cycle pulse: 0 channel switch, 1 conversion done
    task automatic pulse(input bit which);
        @(posedge clk);
        #1;
        if (which) conversion_done = 1'b1;
        else channel_switch = 1'b1;
        @(posedge clk);
        #1;
        conversion_done = 1'b0;
        channel_switch = 1'b0;
    endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import acmr_pkg::*;
    // ----------------------------------------
    // clock, reset, wiring
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_lvl = 1'b0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, channel_switch, conversion_done, clock_io_out, clock_io_oe, filter_reset;
    logic conversion_start, result_ready, input_process_en, power_down, reference_enable;
    logic reference_output_pin, settled_output_only, int_osc_en, ext_clk_sel, xtal_en;
    acmr_op_t op_mode;
    acmr_clk_t clock_source_select;
    int fails = 0;
    int checks_done = 0;
    int n;
    // rows: write word, then expected {start, oe, osc on, power down}
    logic [19:0] rows [8] = '{20'h0000a, 20'h8014e, 20'h20280, 20'ha03c1,
                              20'h0040a, 20'h8054e, 20'h20688, 20'ha07c8};
    // short settle counts keep the run brief; codes 1 to 4 stay full length
    int dly [8] = '{0, ACMR_DLY1_CYC, ACMR_DLY2_CYC, ACMR_DLY3_CYC, ACMR_DLY4_CYC, 40, 50, 60};

    always #20 clk = ~clk;

    acmr_host_model u_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .channel_switch, .conversion_done);

    acmr_mode_ctrl #(.DLY5_CYC(40), .DLY6_CYC(50), .DLY7_CYC(60)) dut (
        .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .channel_switch,
        .conversion_done, .int_osc_level(osc_lvl), .clock_io_in(osc_lvl), .clock_io_out, .clock_io_oe,
        .filter_reset, .conversion_start, .result_ready, .input_process_en, .op_mode, .power_down,
        .reference_enable, .reference_output_pin, .settled_output_only, .clock_source_select,
        .int_osc_en, .ext_clk_sel, .xtal_en);

    // ----------------------------------------
    // compare, wait and verdict
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize;
        if (fails == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // bounded wait for processing; count cycles from the write
    task automatic wait_proc(output int cyc);
        cyc = 0;
        while (input_process_en !== 1'b1) begin
            @(posedge clk);
            #1;
            cyc++;
            if (cyc > 25000) begin
                fails++;
                summarize();
            end
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        #1;
        chk("reset settled", 16'h1, 16'(settled_output_only));
        chk("reset ref", 16'h0, 16'(reference_enable));
        rst_n = 1'b1;
        u_host.read(8'h01);
        chk("reset value", 16'h2000, reg_rdata);
        // every mode and clock source
        foreach (rows[i]) begin
            osc_lvl = i[2];
            u_host.write(8'h01, rows[i][19:4]);
            chk("filter reset", 16'h1, 16'(filter_reset));
            chk("start", 16'(rows[i][3]), 16'(conversion_start));
            chk("ready clear", 16'h0, 16'(result_ready));
            chk("op mode", 16'(rows[i][10:8]), 16'(op_mode));
            chk("power down", 16'(rows[i][0]), 16'(power_down));
            chk("clock sel", 16'(rows[i][7:6]), 16'(clock_source_select));
            chk("clk pins", 16'({rows[i][7:6] == 2'h2, rows[i][7:6] == 2'h3}), 16'({ext_clk_sel, xtal_en}));
            chk("clk oe", 16'(rows[i][2]), 16'(clock_io_oe));
            chk("clk out", 16'(rows[i][2] & osc_lvl), 16'(clock_io_out));
            chk("osc on", 16'(rows[i][1]), 16'(int_osc_en));
            chk("ref", 16'({2{rows[i][19]}}), 16'({reference_enable, reference_output_pin}));
            chk("settled", 16'(rows[i][17]), 16'(settled_output_only));
            u_host.read(8'h01);
            chk("readback", rows[i][19:4] & 16'he77c, reg_rdata);
        end
        // other addresses are ignored and read zero
        u_host.write(8'h02, 16'h8000);
        u_host.read(8'h02);
        chk("unmapped read", 16'h0000, reg_rdata);
        u_host.read(8'h01);
        chk("unmapped write", 16'ha07c, reg_rdata);
        // settle wait for delay codes 1 to 7
        for (int c = 1; c < 8; c++) begin
            u_host.write(8'h01, 16'(c) << 8);
            wait_proc(n);
            chk("settle window", 16'h1, 16'(n >= dly[c] && n <= dly[c] + 3));
        end
        // a channel switch restarts the wait
        u_host.pulse(1'b0);
        chk("switch drop", 16'h0, 16'(input_process_en));
        wait_proc(n);
        chk("switch window", 16'h1, 16'(n >= 59 && n <= 63));
        // single conversion finishes; a rewrite clears the result
        u_host.write(8'h01, 16'h0010);
        wait_proc(n);
        u_host.pulse(1'b1);
        chk("ready set", 16'h1, 16'(result_ready));
        chk("single ends", 16'h0, 16'(input_process_en));
        u_host.write(8'h01, 16'h0010);
        chk("ready rewrite", 16'h0, 16'(result_ready));
        // zero wait: processing follows the write almost at once, then a quiet spell
        u_host.write(8'h01, 16'h0000);
        wait_proc(n);
        chk("zero window", 16'h1, 16'(n >= 1 && n <= 3));
        repeat (4) @(posedge clk);
        // reset in mid-run restores the register
        u_host.write(8'h01, 16'h8000);
        #5 rst_n = 1'b0;
        #1;
        chk("mid reset ref", 16'h0, 16'(reference_enable));
        chk("mid reset rdata", 16'h0, reg_rdata);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        u_host.read(8'h01);
        chk("second reset", 16'h2000, reg_rdata);
        summarize();
    end
endmodule

// ===== inc/acmr_pkg.sv
package acmr_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ACMR_MODE_REG_ADDR = 8'h01;
    localparam logic [15:0] ACMR_MODE_REG_RST = 16'h2000;
    // writable bits: 15, 14, 13, 10:8, 6:4, 3:2; the rest read as zero
    localparam logic [15:0] ACMR_MODE_REG_WMASK = 16'he77c;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int ACMR_REF_EN_BIT = 15;
    localparam int ACMR_SETTLED_BIT = 13;
    localparam int ACMR_DELAY_LSB = 8;
    localparam int ACMR_MODE_LSB = 4;
    localparam int ACMR_CLKSEL_LSB = 2;

    // ----------------------------------------
    // field encodings
    // ----------------------------------------
    typedef enum logic [2:0] {
        ACMR_OP_CONT = 3'h0,
        ACMR_OP_SINGLE = 3'h1,
        ACMR_OP_STANDBY = 3'h2,
        ACMR_OP_PWRDN = 3'h3,
        ACMR_OP_INT_OFS = 3'h4,
        ACMR_OP_INT_GAIN = 3'h5,
        ACMR_OP_SYS_OFS = 3'h6,
        ACMR_OP_SYS_GAIN = 3'h7
    } acmr_op_t;

    typedef enum logic [1:0] {
        ACMR_CLK_INT_OSC = 2'h0,
        ACMR_CLK_INT_OSC_OUT = 2'h1,
        ACMR_CLK_EXT_IN = 2'h2,
        ACMR_CLK_XTAL = 2'h3
    } acmr_clk_t;

    // ----------------------------------------
    // timing: 25 MHz clock, settle waits round up
    // ----------------------------------------
    localparam int ACMR_CLK_PERIOD_NS = 40;
    localparam int ACMR_CNT_W = 18;
    localparam real ACMR_DLY1_US = 32.0;
    localparam real ACMR_DLY2_US = 128.0;
    localparam real ACMR_DLY3_US = 320.0;
    localparam real ACMR_DLY4_US = 800.0;
    localparam real ACMR_DLY5_MS = 1.6;
    localparam real ACMR_DLY6_MS = 4.0;
    localparam real ACMR_DLY7_MS = 8.0;
    localparam int ACMR_DLY1_CYC = int'($ceil(ACMR_DLY1_US * 1000.0 / ACMR_CLK_PERIOD_NS));
    localparam int ACMR_DLY2_CYC = int'($ceil(ACMR_DLY2_US * 1000.0 / ACMR_CLK_PERIOD_NS));
    localparam int ACMR_DLY3_CYC = int'($ceil(ACMR_DLY3_US * 1000.0 / ACMR_CLK_PERIOD_NS));
    localparam int ACMR_DLY4_CYC = int'($ceil(ACMR_DLY4_US * 1000.0 / ACMR_CLK_PERIOD_NS));
    localparam int ACMR_DLY5_CYC = int'($ceil(ACMR_DLY5_MS * 1000000.0 / ACMR_CLK_PERIOD_NS));
    localparam int ACMR_DLY6_CYC = int'($ceil(ACMR_DLY6_MS * 1000000.0 / ACMR_CLK_PERIOD_NS));
    localparam int ACMR_DLY7_CYC = int'($ceil(ACMR_DLY7_MS * 1000000.0 / ACMR_CLK_PERIOD_NS));

endpackage

// ===== rtl/acmr_mode_ctrl.sv
`timescale 1ns/1ps
module acmr_mode_ctrl #(
    parameter int DLY3_CYC = acmr_pkg::ACMR_DLY3_CYC,
    parameter int DLY4_CYC = acmr_pkg::ACMR_DLY4_CYC,
    parameter int DLY5_CYC = acmr_pkg::ACMR_DLY5_CYC,
    parameter int DLY6_CYC = acmr_pkg::ACMR_DLY6_CYC,
    parameter int DLY7_CYC = acmr_pkg::ACMR_DLY7_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic channel_switch,
    input wire logic conversion_done,
    input wire logic int_osc_level,
    input wire logic clock_io_in,
    output logic clock_io_out,
    output logic clock_io_oe,
    output logic filter_reset,
    output logic conversion_start,
    output logic result_ready,
    output logic input_process_en,
    output acmr_pkg::acmr_op_t op_mode,
    output logic power_down,
    output logic reference_enable,
    output logic reference_output_pin,
    output logic settled_output_only,
    output acmr_pkg::acmr_clk_t clock_source_select,
    output logic int_osc_en,
    output logic ext_clk_sel,
    output logic xtal_en
);
    import acmr_pkg::*;

    typedef enum logic [1:0] {ACMR_ST_IDLE, ACMR_ST_SETTLE, ACMR_ST_PROCESS} acmr_state_t;

    logic [15:0] conversion_mode_register_ff;
    logic [15:0] nxt_conversion_mode_register;
    logic [15:0] reg_rdata_ff;
    logic wr_hit;
    logic filter_reset_ff;
    logic conv_start_ff;
    logic result_ready_ff;
    acmr_state_t state_ff;
    acmr_state_t nxt_state;
    acmr_op_t new_op;
    acmr_op_t cur_op;
    logic new_active;
    logic one_shot;
    logic [2:0] dly_code;
    logic [ACMR_CNT_W-1:0] dly_cycles;
    logic timer_start;
    logic timer_busy;
    logic timer_done;

    // ----------------------------------------
    // register write and read
    // ----------------------------------------
    assign wr_hit = reg_wr && (reg_addr == ACMR_MODE_REG_ADDR);
    // reserved read-only bits are masked off, so a careless host cannot set them
    assign nxt_conversion_mode_register = reg_wdata & ACMR_MODE_REG_WMASK;

    // mode register, loaded on any write to its address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_mode_register_ff <= ACMR_MODE_REG_RST;
        end else if (wr_hit) begin
            conversion_mode_register_ff <= nxt_conversion_mode_register;
        end
    end

    // read data registered one edge after the strobe; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= '0;
        end else if (reg_rd) begin
            reg_rdata_ff <= (reg_addr == ACMR_MODE_REG_ADDR) ? conversion_mode_register_ff : 16'h0000;
        end
    end
    assign reg_rdata = reg_rdata_ff;

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    assign cur_op = acmr_op_t'(conversion_mode_register_ff[ACMR_MODE_LSB +: 3]);
    assign new_op = acmr_op_t'(nxt_conversion_mode_register[ACMR_MODE_LSB +: 3]);
    assign new_active = (new_op != ACMR_OP_STANDBY) && (new_op != ACMR_OP_PWRDN);
    // single conversion and every calibration stop after one result
    assign one_shot = (cur_op != ACMR_OP_CONT);
    assign dly_code = conversion_mode_register_ff[ACMR_DELAY_LSB +: 3];

    assign op_mode = cur_op;
    assign power_down = (cur_op == ACMR_OP_PWRDN);
    assign reference_enable = conversion_mode_register_ff[ACMR_REF_EN_BIT];
    assign reference_output_pin = conversion_mode_register_ff[ACMR_REF_EN_BIT];
    assign settled_output_only = conversion_mode_register_ff[ACMR_SETTLED_BIT];

    // ----------------------------------------
    // clock source
    // ----------------------------------------
    assign clock_source_select = acmr_clk_t'(conversion_mode_register_ff[ACMR_CLKSEL_LSB +: 2]);
    assign int_osc_en = (clock_source_select == ACMR_CLK_INT_OSC) ||
                        (clock_source_select == ACMR_CLK_INT_OSC_OUT);
    assign clock_io_oe = (clock_source_select == ACMR_CLK_INT_OSC_OUT);
    // pin is only driven while the oscillator is routed out; low otherwise
    assign clock_io_out = clock_io_oe & int_osc_level;
    assign ext_clk_sel = (clock_source_select == ACMR_CLK_EXT_IN);
    assign xtal_en = (clock_source_select == ACMR_CLK_XTAL);

    // ----------------------------------------
    // settle delay lookup
    // ----------------------------------------
    always_comb begin
        unique case (dly_code)
            3'h0: dly_cycles = '0;
            3'h1: dly_cycles = ACMR_CNT_W'(ACMR_DLY1_CYC);
            3'h2: dly_cycles = ACMR_CNT_W'(ACMR_DLY2_CYC);
            3'h3: dly_cycles = ACMR_CNT_W'(DLY3_CYC);
            3'h4: dly_cycles = ACMR_CNT_W'(DLY4_CYC);
            3'h5: dly_cycles = ACMR_CNT_W'(DLY5_CYC);
            3'h6: dly_cycles = ACMR_CNT_W'(DLY6_CYC);
            3'h7: dly_cycles = ACMR_CNT_W'(DLY7_CYC);
        endcase
    end

    acmr_settle_timer #(
        .CNT_W(ACMR_CNT_W)
    ) u_settle (
        .clk(clk),
        .rst_n(rst_n),
        .start(timer_start),
        .load_cycles(dly_cycles),
        .busy(timer_busy),
        .done(timer_done)
    );

    // ----------------------------------------
    // conversion sequencing
    // ----------------------------------------
    // a write of an active mode restarts from settling; a channel switch during processing re-settles unless a one-shot result arrives with it
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ACMR_ST_IDLE: nxt_state = state_ff;
            ACMR_ST_SETTLE: begin
                if (timer_done) begin
                    nxt_state = ACMR_ST_PROCESS;
                end
            end
            ACMR_ST_PROCESS: begin
                if (conversion_done && one_shot) begin
                    nxt_state = ACMR_ST_IDLE;
                end else if (channel_switch) begin
                    nxt_state = ACMR_ST_SETTLE;
                end
            end
        endcase
        if (conv_start_ff) begin
            nxt_state = ACMR_ST_SETTLE;
        end
        if (wr_hit) begin // a new write stops the old run; standby and power-down stay idle
            nxt_state = ACMR_ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ACMR_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the timer loads from the register, so it is started the edge after the write lands
    assign timer_start = conv_start_ff ||
                         ((state_ff == ACMR_ST_PROCESS) && channel_switch && !(conversion_done && one_shot));
    assign input_process_en = (state_ff == ACMR_ST_PROCESS) && !timer_busy;

    // write side effects: one-cycle filter reset and start pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_reset_ff <= 1'b0;
            conv_start_ff <= 1'b0;
        end else begin
            filter_reset_ff <= wr_hit;
            conv_start_ff <= wr_hit && new_active;
        end
    end
    assign filter_reset = filter_reset_ff;
    assign conversion_start = conv_start_ff;

    // result ready flag; a result arriving with the write still sets it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_ready_ff <= 1'b0;
        end else if (conversion_done && (state_ff == ACMR_ST_PROCESS)) begin
            result_ready_ff <= 1'b1;
        end else if (wr_hit) begin
            result_ready_ff <= 1'b0;
        end
    end
    assign result_ready = result_ready_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    logic seen_edge_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_edge_ff <= 1'b0;
        end else begin
            seen_edge_ff <= 1'b1;
        end
    end

    // cycles since the last write, saturating, so long waits are checked without unrolling
    logic [ACMR_CNT_W-1:0] since_wr_ff;
    logic [2:0] last_dly_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_wr_ff <= '0;
            last_dly_ff <= 3'h0;
        end else if (wr_hit) begin
            since_wr_ff <= '0;
            last_dly_ff <= reg_wdata[ACMR_DELAY_LSB +: 3];
        end else if (since_wr_ff != '1) begin
            since_wr_ff <= since_wr_ff + ACMR_CNT_W'(1);
        end
    end

    property p_write_restarts;
        @(posedge clk) disable iff (!rst_n)
        wr_hit && !conversion_done |=> filter_reset && !result_ready ##1 (filter_reset == $past(wr_hit));
    endproperty
    a_write_restarts: assert property (p_write_restarts) else $error("write did not reset filter");

    property p_ref_follows;
        @(posedge clk) disable iff (!rst_n)
        wr_hit |=> reference_output_pin == $past(reg_wdata[15]);
    endproperty
    a_ref_follows: assert property (p_ref_follows) else $error("reference enable wrong");

    property p_settled_follows;
        @(posedge clk) disable iff (!rst_n)
        wr_hit |=> settled_output_only == $past(reg_wdata[13]);
    endproperty
    a_settled_follows: assert property (p_settled_follows) else $error("settled option wrong");

    property p_delay_32us;
        @(posedge clk) disable iff (!rst_n)
        input_process_en && last_dly_ff == 3'h1 |-> since_wr_ff >= ACMR_CNT_W'(ACMR_DLY1_CYC);
    endproperty
    a_delay_32us: assert property (p_delay_32us) else $error("settle wait too short");

    property p_delay_zero;
        @(posedge clk) disable iff (!rst_n)
        wr_hit && reg_wdata[10:8] == 3'h0 && reg_wdata[6:4] == 3'h0 ##1 (!wr_hit && !channel_switch)[*4]
        |-> input_process_en;
    endproperty
    a_delay_zero: assert property (p_delay_zero) else $error("zero wait did not start processing");

    property p_power_down;
        @(posedge clk) disable iff (!rst_n)
        wr_hit && reg_wdata[6:4] == 3'h3 |=> power_down && !conversion_start ##1 !input_process_en;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down not entered");

    property p_ext_clock;
        @(posedge clk) disable iff (!rst_n)
        wr_hit && reg_wdata[3:2] == 2'h2 |=> ext_clk_sel && !clock_io_oe && !int_osc_en;
    endproperty
    a_ext_clock: assert property (p_ext_clock) else $error("external clock select wrong");

    property p_osc_on;
        @(posedge clk) disable iff (!rst_n)
        wr_hit && !reg_wdata[3] |=> int_osc_en && (clock_io_oe == $past(reg_wdata[2]));
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("oscillator not enabled");

    property p_reset_value;
        @(posedge clk) disable iff (!rst_n)
        !seen_edge_ff |-> conversion_mode_register_ff == 16'h2000 && op_mode == ACMR_OP_CONT;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad mode register reset value");
endmodule

// ===== rtl/acmr_settle_timer.sv
`timescale 1ns/1ps
module acmr_settle_timer #(
    parameter int CNT_W = acmr_pkg::ACMR_CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [CNT_W-1:0] load_cycles,
    output logic busy,
    output logic done
);
    import acmr_pkg::*;

    logic [CNT_W-1:0] count_ff;
    logic busy_ff;
    logic done_ff;

    // ----------------------------------------
    // down counter, restart wins over a run in progress
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (start) begin
            // zero load finishes on the very next edge
            count_ff <= load_cycles;
            busy_ff <= (load_cycles > CNT_W'(1));
            done_ff <= (load_cycles <= CNT_W'(1));
        end else if (busy_ff) begin
            count_ff <= count_ff - CNT_W'(1);
            busy_ff <= (count_ff > CNT_W'(2));
            done_ff <= (count_ff == CNT_W'(2));
        end else begin
            done_ff <= 1'b0;
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
endmodule
